// [common/wbc_pkg.sv]
// constants and carrier types of the write-back cache state keeper
// assumes one clock, core_clk at 25 MHz, and a classic wishbone master
//
// ---------------------------------------------------------------
// Notes on behaviour
// ---------------------------------------------------------------
// Notes on behaviour
// R01 - every line keeps a two-bit state beside its address tag
// R02 - states: 00 invalid, 01 exclusive, 10 modified, 11 shared
// R03 - only read misses allocate; write misses go to bus unallocated
// R04 - write hit modified/exclusive stays local; shared also goes to bus
// R05 - invalid lines hold nothing and never hit, snoops included
// R06 - a line filled under write-through is held shared
// R07 - a snoop hitting a modified line always writes it back
// R08 - snoop hit modified forces master off, line written back, master retries
// R09 - a new line first takes an invalid way of the set
// R10 - otherwise pseudo-LRU picks the victim among four ways
// R11 - a modified victim moves to the copy-back buffer, then refill
// R12 - cacheability from disable bit, no-write-through bit, enable input at burst; the code uses only the disable bit and enable input
// R13 - cache-disable bit: 0 cache on, 1 cache off
// R14 - no-write-through bit: 0 write-through and snoops on, 1 off
// R15 - hard reset sets both control bits to 1
// R16 - soft reset keeps lines and control bits; hard reset invalidates
// R17 - policy low at first burst-ready: all four words stored, line write-through
// R18 - policy high at first burst-ready: whole line write-back
// R19 - per-line policy only if policy input high at hard reset
// R20 - line state checked on every write hit and snoop hit
// R21 - every write to a write-through line also goes to the bus
// R22 - other masters show all transfers on the local bus
// R23 - write hit on exclusive stays local and makes the line modified
// R24 - page write-through attribute at fill forces the line shared
// R25 - snoop result driven two cycles after strobe, high only if modified
// R26 - modified victim waits while the copy-back buffer is still full
// R27 - hard reset invalidates every line and clears pseudo-LRU bits
// ---------------------------------------------------------------
package wbc_pkg;
   localparam int ADDR_W = 32;
   localparam int OFF_W = 4;
   localparam int IDX_W = 4;
   localparam int SETS = 16;
   localparam int WAYS = 4;
   localparam int WAY_W = 2;
   localparam int TAG_W = ADDR_W - OFF_W - IDX_W;
   localparam int LINE_W = ADDR_W - OFF_W;
   localparam int BEAT_W = 2;
   localparam logic [BEAT_W-1:0] LAST_BEAT = 2'h3;
   localparam logic [1:0] ST_INV = 2'h0;
   localparam logic [1:0] ST_EXC = 2'h1;
   localparam logic [1:0] ST_MOD = 2'h2;
   localparam logic [1:0] ST_SHR = 2'h3;
   localparam logic [2:0] PLRU_RST = 3'h0;
   localparam int WB_ADR_W = 8;
   localparam logic [WB_ADR_W-1:0] CTRL_OFF = 8'h00;
   localparam logic [WB_ADR_W-1:0] STAT_OFF = 8'h04;
   localparam int CD_BIT = 0;
   localparam int NW_BIT = 1;
   localparam logic CD_RST = 1'h1;
   localparam logic NW_RST = 1'h1;
   localparam int ST_WBMODE_BIT = 0;
   localparam int ST_CBFULL_BIT = 1;
   localparam int ST_BUSY_BIT = 2;
   localparam int ST_SNOOP_HIT_MODIFIED_OUT_BIT = 3;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic write;
      logic page_wt;
   } wbc_cpu_req_t;

   typedef struct packed {
      logic hit;
      logic to_bus;
   } wbc_cpu_resp_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic inv;
   } wbc_snoop_req_t;
endpackage

// [src/wbc_state_keeper.sv]
// line state, replacement and snoop logic of a four-way write-back cache
// assumes synchronous inputs on core_clk and a classic wishbone master
//
// Design decisions made here: the register offsets and the Wishbone slave port.
module wbc_state_keeper (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic soft_reset_in,
   input wire logic line_policy_in,
   input wire logic cpu_req_valid,
   input wire wbc_pkg::wbc_cpu_req_t cpu_req,
   output logic cpu_ready,
   output logic cpu_done,
   output wbc_pkg::wbc_cpu_resp_t cpu_resp,
   input wire logic cache_enable_in,
   input wire logic burst_ready_in,
   output logic fill_active_out,
   output logic [wbc_pkg::LINE_W-1:0] fill_addr_out,
   output logic cb_valid_out,
   output logic [wbc_pkg::LINE_W-1:0] cb_addr_out,
   input wire logic cb_drained_in,
   input wire logic snoop_strobe_in,
   input wire wbc_pkg::wbc_snoop_req_t snoop_req,
   output logic snoop_hit_modified_out,
   output logic snoop_wback_out,
   output logic [wbc_pkg::LINE_W-1:0] snoop_wback_addr_out,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [wbc_pkg::WB_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {S_IDLE, S_LOOKUP, S_CB_WAIT, S_FILL} wbc_fsm_t;

   logic [1:0] st_mem [wbc_pkg::SETS][wbc_pkg::WAYS]; // R01
   logic [wbc_pkg::TAG_W-1:0] tag_mem [wbc_pkg::SETS][wbc_pkg::WAYS]; // R01
   logic [2:0] plru_mem [wbc_pkg::SETS];
   wbc_fsm_t fsm_reg;
   wbc_pkg::wbc_cpu_req_t req_reg;
   wbc_pkg::wbc_cpu_resp_t resp_reg;
   logic done_reg;
   logic cd_reg, nw_reg, wb_mode_reg, strap_done_reg;
   logic [wbc_pkg::BEAT_W-1:0] beat_reg;
   logic fill_cacheable_reg, fill_excl_reg;
   logic [wbc_pkg::WAY_W-1:0] vic_way_reg;
   logic cb_valid_reg;
   logic [wbc_pkg::LINE_W-1:0] cb_addr_reg;
   logic sn1_valid_reg;
   wbc_pkg::wbc_snoop_req_t sn1_reg;
   logic snoop_hit_modified_out_reg, wback_reg;
   logic [wbc_pkg::LINE_W-1:0] wback_addr_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic logic [wbc_pkg::WAY_W-1:0] first_way(
      input logic [wbc_pkg::WAYS-1:0] v);
      logic [wbc_pkg::WAY_W-1:0] w;
      w = '0;
      for (int i = wbc_pkg::WAYS - 1; i >= 0; i--) begin
         if (v[i]) begin
            w = wbc_pkg::WAY_W'(i);
         end
      end
      return w;
   endfunction

   // tree: bit0 picks the half, bit1/bit2 the way inside it
   function automatic logic [wbc_pkg::WAY_W-1:0] plru_victim(
      input logic [2:0] p);
      return p[0] ? {1'b1, p[2]} : {1'b0, p[1]};
   endfunction

   function automatic logic [2:0] plru_touch(input logic [2:0] p,
      input logic [wbc_pkg::WAY_W-1:0] w);
      logic [2:0] n;
      n = p;
      n[0] = ~w[1];
      if (w[1]) begin
         n[2] = ~w[0];
      end else begin
         n[1] = ~w[0];
      end
      return n;
   endfunction

   // ---------------------------------------------------------------
   // processor lookup
   // ---------------------------------------------------------------
   logic [wbc_pkg::IDX_W-1:0] ridx, sidx;
   logic [wbc_pkg::TAG_W-1:0] rtag, stag;
   logic [wbc_pkg::WAYS-1:0] cpu_hitv, invv, sn_hitv;
   logic cpu_hit, any_inv, vic_mod, sn_hit, sn_mod, sn_cb_hit;
   logic [wbc_pkg::WAY_W-1:0] hway, vic_way, sn_way;
   logic [1:0] hst;

   assign ridx = req_reg.addr[wbc_pkg::OFF_W +: wbc_pkg::IDX_W];
   assign rtag = req_reg.addr[wbc_pkg::ADDR_W-1 -: wbc_pkg::TAG_W];
   assign sidx = sn1_reg.addr[wbc_pkg::OFF_W +: wbc_pkg::IDX_W];
   assign stag = sn1_reg.addr[wbc_pkg::ADDR_W-1 -: wbc_pkg::TAG_W];

   generate
      for (genvar w = 0; w < wbc_pkg::WAYS; w++) begin : g_cmp
         assign invv[w] = st_mem[ridx][w] == wbc_pkg::ST_INV; // R05
         assign cpu_hitv[w] = !invv[w] && tag_mem[ridx][w] == rtag; // R05
         assign sn_hitv[w] = st_mem[sidx][w] != wbc_pkg::ST_INV
            && tag_mem[sidx][w] == stag; // R05
      end
   endgenerate

   assign cpu_hit = |cpu_hitv;
   assign hway = first_way(cpu_hitv);
   assign hst = st_mem[ridx][hway];
   assign any_inv = |invv;
   assign vic_way = any_inv ? first_way(invv) // R09
      : plru_victim(plru_mem[ridx]); // R10
   assign vic_mod = st_mem[ridx][vic_way] == wbc_pkg::ST_MOD;

   logic lk_read_miss, lk_wr_excl, install, cacheable_now;
   assign lk_read_miss = fsm_reg == S_LOOKUP && !req_reg.write && !cpu_hit;
   assign lk_wr_excl = fsm_reg == S_LOOKUP && req_reg.write && cpu_hit
      && hst == wbc_pkg::ST_EXC;
   // disable bit and enable input judged at the burst itself
   assign cacheable_now = beat_reg == '0 ? !cd_reg && cache_enable_in // R12
      : fill_cacheable_reg;
   assign install = fsm_reg == S_FILL && burst_ready_in
      && beat_reg == wbc_pkg::LAST_BEAT && cacheable_now;

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         fsm_reg <= S_IDLE;
         req_reg <= '0;
         beat_reg <= '0;
         vic_way_reg <= '0;
      end else if (soft_reset_in) begin
         fsm_reg <= S_IDLE; // R16
         beat_reg <= '0;
      end else begin
         case (fsm_reg)
            S_IDLE: begin
               if (cpu_req_valid) begin
                  req_reg <= cpu_req;
                  fsm_reg <= S_LOOKUP;
               end
            end
            S_LOOKUP: begin
               vic_way_reg <= vic_way;
               if (req_reg.write || cpu_hit) begin
                  fsm_reg <= S_IDLE; // R03
               end else if (vic_mod && !any_inv && cb_valid_reg) begin
                  fsm_reg <= S_CB_WAIT; // R26
               end else begin
                  fsm_reg <= S_FILL;
               end
            end
            S_CB_WAIT: begin
               if (!cb_valid_reg) begin
                  fsm_reg <= S_FILL; // R26
               end
            end
            S_FILL: begin
               if (burst_ready_in) begin
                  beat_reg <= beat_reg + 1'b1; // R17
                  if (beat_reg == wbc_pkg::LAST_BEAT) begin
                     fsm_reg <= S_IDLE;
                  end
               end
            end
            default: fsm_reg <= S_IDLE;
         endcase
      end
   end

   // first burst-ready fixes cacheability and line policy
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         fill_cacheable_reg <= 1'b0;
         fill_excl_reg <= 1'b0;
      end else if (fsm_reg == S_FILL && burst_ready_in && beat_reg == '0) begin
         fill_cacheable_reg <= !cd_reg && cache_enable_in; // R12 R13
         // write-through, page attribute or wt strap all give shared
         fill_excl_reg <= wb_mode_reg && line_policy_in // R17 R18 R19
            && !req_reg.page_wt; // R24 R06
      end
   end

   // answer to the processor
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         done_reg <= 1'b0;
         resp_reg <= '0;
      end else begin
         done_reg <= 1'b0;
         if (fsm_reg == S_LOOKUP && (req_reg.write || cpu_hit)) begin
            done_reg <= 1'b1;
            resp_reg.hit <= cpu_hit;
            // write miss bypasses; shared means write-through
            resp_reg.to_bus <= req_reg.write && (!cpu_hit // R03
               || (hst == wbc_pkg::ST_SHR && !nw_reg)); // R04 R21 R14
         end else if (fsm_reg == S_FILL && burst_ready_in
            && beat_reg == wbc_pkg::LAST_BEAT) begin
            done_reg <= 1'b1;
            resp_reg.hit <= 1'b0;
            resp_reg.to_bus <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // line state, tags and replacement bits
   // ---------------------------------------------------------------
   logic sn_upd;
   logic [1:0] sn_new;
   assign sn_upd = sn1_valid_reg && sn_hit && (sn1_reg.inv || sn_mod);
   assign sn_new = sn1_reg.inv ? wbc_pkg::ST_INV : wbc_pkg::ST_SHR;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int s = 0; s < wbc_pkg::SETS; s++) begin
            plru_mem[s] <= wbc_pkg::PLRU_RST; // R27
            for (int w = 0; w < wbc_pkg::WAYS; w++) begin
               st_mem[s][w] <= wbc_pkg::ST_INV; // R27 R16
            end
         end
      end else begin
         if (lk_wr_excl) begin
            st_mem[ridx][hway] <= wbc_pkg::ST_MOD; // R23 R20
         end
         if (fsm_reg == S_LOOKUP && cpu_hit) begin
            plru_mem[ridx] <= plru_touch(plru_mem[ridx], hway);
         end
         if (install) begin
            st_mem[ridx][vic_way_reg] <= fill_excl_reg ? wbc_pkg::ST_EXC
               : wbc_pkg::ST_SHR; // R02 R06
            plru_mem[ridx] <= plru_touch(plru_mem[ridx], vic_way_reg);
         end
         // snoop update is last so it wins over a local change
         if (sn_upd) begin
            st_mem[sidx][sn_way] <= sn_new; // R20
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (install) begin
         tag_mem[ridx][vic_way_reg] <= rtag;
      end
   end

   // ---------------------------------------------------------------
   // copy-back buffer
   // ---------------------------------------------------------------
   logic cb_push;
   assign cb_push = install
      && st_mem[ridx][vic_way_reg] == wbc_pkg::ST_MOD; // R11

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cb_valid_reg <= 1'b0;
         cb_addr_reg <= '0;
      end else begin
         // push is last so a same-cycle drain cannot lose it
         if (cb_drained_in || (sn1_valid_reg && sn_cb_hit)) begin
            cb_valid_reg <= 1'b0;
         end
         if (cb_push) begin
            cb_valid_reg <= 1'b1; // R11
            cb_addr_reg <= {tag_mem[ridx][vic_way_reg], ridx};
         end
      end
   end

   // ---------------------------------------------------------------
   // snoop pipe: strobe edge, compare edge, result
   // ---------------------------------------------------------------
   assign sn_hit = |sn_hitv;
   assign sn_way = first_way(sn_hitv);
   assign sn_mod = sn_hit && st_mem[sidx][sn_way] == wbc_pkg::ST_MOD;
   assign sn_cb_hit = cb_valid_reg
      && cb_addr_reg == sn1_reg.addr[wbc_pkg::ADDR_W-1:wbc_pkg::OFF_W];

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sn1_valid_reg <= 1'b0;
         sn1_reg <= '0;
         snoop_hit_modified_out_reg <= 1'b0;
         wback_reg <= 1'b0;
         wback_addr_reg <= '0;
      end else begin
         sn1_valid_reg <= snoop_strobe_in && !nw_reg; // R14
         if (snoop_strobe_in) begin
            sn1_reg <= snoop_req;
         end
         snoop_hit_modified_out_reg <= sn1_valid_reg && (sn_mod || sn_cb_hit); // R25 R08
         wback_reg <= sn1_valid_reg && (sn_mod || sn_cb_hit); // R07
         if (sn1_valid_reg) begin
            wback_addr_reg <= sn1_reg.addr[wbc_pkg::ADDR_W-1:wbc_pkg::OFF_W];
         end
      end
   end

   // ---------------------------------------------------------------
   // control bits, strap and wishbone slave
   // ---------------------------------------------------------------
   logic wb_hit;
   assign wb_hit = wb_cyc_i && wb_stb_i;

   // strap is caught on the first edge after release, not in reset
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wb_mode_reg <= 1'b0;
         strap_done_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         wb_mode_reg <= line_policy_in; // R19
         strap_done_reg <= 1'b1;
      end
   end

   // soft reset is deliberately absent here
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cd_reg <= wbc_pkg::CD_RST; // R15
         nw_reg <= wbc_pkg::NW_RST; // R15
      end else if (wb_hit && ack_reg && wb_we_i && wb_sel_i[0]
         && wb_adr_i == wbc_pkg::CTRL_OFF) begin
         cd_reg <= wb_dat_i[wbc_pkg::CD_BIT]; // R13
         nw_reg <= wb_dat_i[wbc_pkg::NW_BIT]; // R14
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ack_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         ack_reg <= wb_hit && !ack_reg;
         rdata_reg <= '0;
         if (wb_adr_i == wbc_pkg::CTRL_OFF) begin
            rdata_reg[wbc_pkg::CD_BIT] <= cd_reg;
            rdata_reg[wbc_pkg::NW_BIT] <= nw_reg;
         end else if (wb_adr_i == wbc_pkg::STAT_OFF) begin
            rdata_reg[wbc_pkg::ST_WBMODE_BIT] <= wb_mode_reg;
            rdata_reg[wbc_pkg::ST_CBFULL_BIT] <= cb_valid_reg;
            rdata_reg[wbc_pkg::ST_BUSY_BIT] <= fsm_reg != S_IDLE;
            rdata_reg[wbc_pkg::ST_SNOOP_HIT_MODIFIED_OUT_BIT] <= snoop_hit_modified_out_reg;
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;
   assign cpu_ready = fsm_reg == S_IDLE && !soft_reset_in;
   assign cpu_done = done_reg;
   assign cpu_resp = resp_reg;
   assign fill_active_out = fsm_reg == S_FILL;
   assign fill_addr_out = req_reg.addr[wbc_pkg::ADDR_W-1:wbc_pkg::OFF_W];
   assign cb_valid_out = cb_valid_reg;
   assign cb_addr_out = cb_addr_reg;
   assign snoop_hit_modified_out = snoop_hit_modified_out_reg;
   assign snoop_wback_out = wback_reg;
   assign snoop_wback_addr_out = wback_addr_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence snoop_taken_s;
      snoop_strobe_in && !nw_reg;
   endsequence

   sequence found_mod_s;
      ##1 sn_mod;
   endsequence

   snoop_hit_modified_out_timing_a: assert property (@(posedge core_clk) disable iff (reset) // R25
      snoop_taken_s ##0 found_mod_s |=> snoop_hit_modified_out)
      else $error("modified snoop hit not reported two cycles on");

   snoop_hit_modified_out_cause_a: assert property (@(posedge core_clk) disable iff (reset) // R05
      snoop_hit_modified_out |-> $past(sn1_valid_reg) && $past(sn_hit
         || sn_cb_hit))
      else $error("snoop result without a valid hit");

   snoop_hit_modified_out_wback_a: assert property (@(posedge core_clk) disable iff (reset) // R07
      snoop_hit_modified_out |-> snoop_wback_out)
      else $error("modified snoop hit without write-back");

   excl_to_mod_a: assert property (@(posedge core_clk) disable iff (reset) // R23
      lk_wr_excl && !sn_upd |=> st_mem[$past(ridx)][$past(hway)]
         == wbc_pkg::ST_MOD && cpu_done && !cpu_resp.to_bus)
      else $error("exclusive write hit did not become modified");

   wr_miss_a: assert property (@(posedge core_clk) disable iff (reset) // R03
      fsm_reg == S_LOOKUP && req_reg.write && !cpu_hit && !soft_reset_in
      |=> cpu_done && cpu_resp.to_bus && fsm_reg == S_IDLE)
      else $error("write miss allocated or stayed off the bus");

   shared_wr_a: assert property (@(posedge core_clk) disable iff (reset) // R04
      fsm_reg == S_LOOKUP && req_reg.write && cpu_hit
      && hst == wbc_pkg::ST_SHR && !nw_reg |=> cpu_resp.to_bus)
      else $error("shared write hit kept off the bus");

   wt_fill_a: assert property (@(posedge core_clk) disable iff (reset) // R19
      install && (!wb_mode_reg || req_reg.page_wt) |-> !fill_excl_reg)
      else $error("write-through fill not marked shared");

   cb_stall_a: assert property (@(posedge core_clk) disable iff (reset) // R26
      lk_read_miss && vic_mod && !any_inv && cb_valid_reg && !soft_reset_in
      |=> fsm_reg == S_CB_WAIT)
      else $error("replacement overran a full copy-back buffer");

   cd_block_a: assert property (@(posedge core_clk) disable iff (reset) // R13
      fsm_reg == S_FILL && burst_ready_in && beat_reg == '0 && cd_reg
      |=> !fill_cacheable_reg)
      else $error("fill cached while cache disabled");
endmodule

// [verification/wbc_sys_model.sv]
// system core logic model: line-fill beats and copy-back drain
// assumes the state keeper's fill and copy-back outputs on core_clk
module wbc_sys_model (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic fill_active_out,
   input wire logic cb_valid_out,
   input wire logic cb_hold,
   input wire logic [3:0] beat_gap,
   output logic burst_ready_in,
   output logic cb_drained_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] gap_reg;

   // ---------------------------------------------------------------
   // fill beats, one pulse per beat, spaced by beat_gap
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         burst_ready_in <= 1'b0;
         gap_reg <= 4'h0;
      end else if (fill_active_out && !burst_ready_in) begin
         if (gap_reg == beat_gap) begin
            burst_ready_in <= 1'b1;
            gap_reg <= 4'h0;
         end else begin
            gap_reg <= gap_reg + 4'h1;
         end
      end else begin
         burst_ready_in <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // copy-back drain; hold lets the bench keep the buffer full
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cb_drained_in <= 1'b0;
      end else begin
         cb_drained_in <= cb_valid_out && !cb_hold && !cb_drained_in;
      end
   end
endmodule

// [verification/wbc_state_keeper_bench.sv]
// bench for the cache state keeper: cpu, snoop and wishbone sequences
// assumes wbc_sys_model answers fills and drains the copy-back buffer
module wbc_state_keeper_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, reset, soft_reset_in, line_policy_in, cpu_req_valid;
   logic cpu_ready, cpu_done, cache_enable_in, burst_ready_in;
   logic fill_active_out, cb_valid_out, cb_drained_in, snoop_strobe_in;
   logic snoop_hit_modified_out, snoop_wback_out, wb_cyc_i, wb_stb_i;
   logic wb_we_i, wb_ack_o, cb_hold;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, d;
   logic [27:0] cba;
   wbc_pkg::wbc_cpu_req_t cpu_req;
   wbc_pkg::wbc_cpu_resp_t cpu_resp;
   wbc_pkg::wbc_snoop_req_t snoop_req;
   int err_count = 0;
   int compares = 0;
   time done_t, rel_t;

   wbc_state_keeper u_wbc_state_keeper (.core_clk(core_clk), .reset(reset),
      .soft_reset_in(soft_reset_in), .line_policy_in(line_policy_in),
      .cpu_req_valid(cpu_req_valid), .cpu_req(cpu_req),
      .cpu_ready(cpu_ready), .cpu_done(cpu_done), .cpu_resp(cpu_resp),
      .cache_enable_in(cache_enable_in), .burst_ready_in(burst_ready_in),
      .fill_active_out(fill_active_out), .fill_addr_out(),
      .cb_valid_out(cb_valid_out), .cb_addr_out(cba),
      .cb_drained_in(cb_drained_in), .snoop_strobe_in(snoop_strobe_in),
      .snoop_req(snoop_req), .snoop_hit_modified_out(snoop_hit_modified_out),
      .snoop_wback_out(snoop_wback_out), .snoop_wback_addr_out(),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   wbc_sys_model u_wbc_sys_model (.core_clk(core_clk), .reset(reset),
      .fill_active_out(fill_active_out), .cb_valid_out(cb_valid_out),
      .cb_hold(cb_hold), .beat_gap(4'h1), .burst_ready_in(burst_ready_in),
      .cb_drained_in(cb_drained_in));

   // ---------------------------------------------------------------
   // access tasks and compare
   // ---------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wb_xfer(input logic w, input logic [7:0] a,
                          input logic [31:0] wd, output logic [31:0] rd);
      @(posedge core_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
      wb_adr_i <= a;
      wb_dat_i <= wd;
      do @(posedge core_clk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
   endtask
   // resp is {hit, to_bus}; cpu_ready is looked at mid-cycle
   task automatic cpu(input logic [31:0] a, input logic w, input logic page_write_through_attr,
                      input logic [1:0] exp);
      do @(negedge core_clk); while (cpu_ready !== 1'b1);
      @(posedge core_clk);
      cpu_req_valid <= 1'b1;
      cpu_req <= '{addr: a, write: w, page_wt: page_write_through_attr};
      @(posedge core_clk);
      cpu_req_valid <= 1'b0;
      do @(negedge core_clk); while (cpu_done !== 1'b1);
      done_t = $time;
      chk({30'h0, cpu_resp}, {30'h0, exp});
   endtask
   task automatic snp(input logic [31:0] a, input logic inv, input logic e);
      @(posedge core_clk);
      snoop_strobe_in <= 1'b1;
      snoop_req <= '{addr: a, inv: inv};
      @(posedge core_clk);
      snoop_strobe_in <= 1'b0;
      @(negedge core_clk);
      @(negedge core_clk);
      chk({30'h0, snoop_hit_modified_out, snoop_wback_out}, {30'h0, e, e});
   endtask
   task automatic wrap_up;
      $display("counts: %0d compares, %0d mismatches", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // watchdog, far beyond the roughly 400 cycles of the tests
   // ---------------------------------------------------------------
   initial begin
      repeat (30000) @(posedge core_clk);
      err_count++;
      wrap_up();
   end

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      {reset, line_policy_in, cache_enable_in} = 3'h7;
      {soft_reset_in, cpu_req_valid, snoop_strobe_in, cb_hold} = 4'h0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      wb_sel_i = 4'hf;
      cpu_req = '0;
      snoop_req = '0;
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      wb_xfer(1'b0, wbc_pkg::CTRL_OFF, 32'h0, d);
      chk(d & 32'h3, 32'h3);
      wb_xfer(1'b0, wbc_pkg::STAT_OFF, 32'h0, d);
      chk(d & 32'h1, 32'h1);
      wb_xfer(1'b0, 8'h40, 32'h0, d);
      chk(d, 32'h0);
      cpu(32'h1010, 1'b0, 1'b0, 2'h1);
      cpu(32'h1010, 1'b0, 1'b0, 2'h1);
      wb_xfer(1'b1, wbc_pkg::CTRL_OFF, 32'h0, d);
      wb_xfer(1'b0, wbc_pkg::CTRL_OFF, 32'h0, d);
      chk(d & 32'h3, 32'h0);
      cache_enable_in <= 1'b0;
      cpu(32'h2020, 1'b0, 1'b0, 2'h1);
      cpu(32'h2020, 1'b0, 1'b0, 2'h1);
      cache_enable_in <= 1'b1;
      $display("test control done");
      cpu(32'h1010, 1'b0, 1'b0, 2'h1);
      cpu(32'h1010, 1'b0, 1'b0, 2'h2);
      cpu(32'h1010, 1'b1, 1'b0, 2'h2);
      snp(32'h1010, 1'b0, 1'b1);
      cpu(32'h1010, 1'b1, 1'b0, 2'h3);
      snp(32'h1010, 1'b1, 1'b0);
      cpu(32'h1010, 1'b1, 1'b0, 2'h1);
      cpu(32'h1010, 1'b0, 1'b0, 2'h1);
      cpu(32'h3030, 1'b0, 1'b1, 2'h1);
      cpu(32'h3030, 1'b1, 1'b0, 2'h3);
      line_policy_in <= 1'b0;
      cpu(32'h4040, 1'b0, 1'b0, 2'h1);
      line_policy_in <= 1'b1;
      cpu(32'h4040, 1'b1, 1'b0, 2'h3);
      $display("test coherency done");
      cb_hold <= 1'b1;
      for (int t = 1; t <= 4; t++) begin
         cpu(32'(t) << 8, 1'b0, 1'b0, 2'h1);
         cpu(32'(t) << 8, 1'b1, 1'b0, 2'h2);
      end
      chk({31'h0, cb_valid_out}, 32'h0);
      cpu(32'h500, 1'b0, 1'b0, 2'h1);
      chk({31'h0, cb_valid_out}, 32'h1);
      chk({4'h0, cba}, 32'h10);
      cpu(32'h500, 1'b1, 1'b0, 2'h2);
      fork
         cpu(32'h600, 1'b0, 1'b0, 2'h1);
         begin
            repeat (40) @(posedge core_clk);
            chk({31'h0, cb_valid_out}, 32'h1);
            rel_t = $time;
            cb_hold <= 1'b0;
         end
      join
      chk({31'h0, done_t > rel_t}, 32'h1);
      $display("test replacement done");
      @(posedge core_clk);
      soft_reset_in <= 1'b1;
      @(posedge core_clk);
      soft_reset_in <= 1'b0;
      cpu(32'h500, 1'b0, 1'b0, 2'h2);
      wb_xfer(1'b0, wbc_pkg::CTRL_OFF, 32'h0, d);
      chk(d & 32'h3, 32'h0);
      {reset, line_policy_in} <= 2'h2;
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      wb_xfer(1'b0, wbc_pkg::CTRL_OFF, 32'h0, d);
      chk(d & 32'h3, 32'h3);
      line_policy_in <= 1'b1;
      wb_xfer(1'b1, wbc_pkg::CTRL_OFF, 32'h0, d);
      cpu(32'h500, 1'b0, 1'b0, 2'h1);
      cpu(32'h500, 1'b1, 1'b0, 2'h3);
      $display("test resets done");
      wrap_up();
   end
endmodule
